// File: pcm_pkg.sv
// constants and register map of the program counter monitor and first parity mask
// =====================================================================
package pcm_pkg;
	// =================================================================
	// register offsets
	localparam logic [15:0] OFF_PC_HIGH = 16'hf460;
	localparam logic [15:0] OFF_PC_LOW = 16'hf461;
	localparam logic [15:0] OFF_CLEAR = 16'hf462;
	localparam logic [15:0] OFF_FRAME_HIGH = 16'hf463;
	localparam logic [15:0] OFF_FRAME_LOW = 16'hf464;
	localparam logic [15:0] OFF_ALL_HIGH = 16'hf465;
	localparam logic [15:0] OFF_ALL_LOW = 16'hf466;
	localparam logic [15:0] OFF_PARITY_MASK = 16'hf467;
	localparam logic [15:0] OFF_IRQ_STATUS = 16'hf470;
	localparam logic [15:0] OFF_IRQ_MASK = 16'hf471;
	// =================================================================
	// field layout
	localparam int CLEAR_BIT = 0;
	localparam int SUB_LSB = 9;
	localparam int SUB_MSB = 12;
	localparam logic [15:0] PARITY_RW_BITS = 16'h1f1f;
	localparam int IRQ_NEW_PEAK = 0;
	localparam int IRQ_FRAME_DONE = 1;
	localparam int IRQ_PARITY = 2;
	localparam logic [2:0] IRQ_RW_BITS = 3'h7;
	// =================================================================
	// reset values
	localparam logic [23:0] PC_RESET = 24'h000000;
	localparam logic [15:0] REG_RESET = 16'h0000;
	localparam logic [2:0] IRQ_RESET = 3'h0;
endpackage : pcm_pkg

// File: pcm_pc_monitor.sv
// program counter monitor with peak tracking and first parity mask register
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
module pcm_pc_monitor (
	// clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// register port
	input wire logic [15:0] regAddr,
	input wire logic [15:0] regWrData,
	input wire logic regWrStb,
	input wire logic regRdStb,
	output logic [15:0] regRdData,
	// core side
	input wire logic [23:0] corePc,
	input wire logic corePcValid,
	input wire logic frameStart,
	output logic pcHold,
	// parity errors of bank 1 subbanks 1..4, index 0 is subbank 1
	input wire logic [3:0] subParityErr,
	output logic panicParity,
	// interrupt
	output logic irq
);
	// =================================================================
	// address decode helper
	function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
		hit = (a == off);
	endfunction : hit

	// =================================================================
	// state
	logic [23:0] pc_reg, pc_next;
	logic [23:0] runMax_reg, runMax_next;
	logic [23:0] framePeak_reg, framePeak_next;
	logic [23:0] allPeak_reg, allPeak_next;
	logic clear_reg, clear_next;
	logic clrPrev_reg, clrPrev_next;
	logic [15:0] pmask_reg, pmask_next;
	logic [2:0] istat_reg, istat_next;
	logic [2:0] imask_reg, imask_next;
	logic [15:0] rd_reg, rd_next;
	logic clearFall;
	logic newPeak;
	logic [3:0] reported;
	logic [2:0] events;
	logic wrHit;

	assign clearFall = clrPrev_reg & ~clear_reg;
	assign reported = subParityErr & ~pmask_reg[pcm_pkg::SUB_MSB:pcm_pkg::SUB_LSB];
	assign newPeak = frameStart & ~clear_reg & ~clearFall & (runMax_reg > allPeak_reg);
	assign events = {|reported, frameStart & ~clear_reg, newPeak};
	assign wrHit = regWrStb;

	// =================================================================
	// counter and peaks
	always_comb begin
		clear_next = clear_reg;
		if (wrHit && hit(regAddr, pcm_pkg::OFF_CLEAR)) begin
			clear_next = regWrData[pcm_pkg::CLEAR_BIT];
		end
		clrPrev_next = clear_reg;
		if (clear_reg) begin
			pc_next = pcm_pkg::PC_RESET;
		end else if (corePcValid) begin
			pc_next = corePc;
		end else begin
			pc_next = pc_reg;
		end
		// the frame peak is the running maximum handed over at each frame start
		if (clear_reg) begin
			runMax_next = pcm_pkg::PC_RESET;
			framePeak_next = pcm_pkg::PC_RESET;
		end else if (frameStart) begin
			runMax_next = pc_reg;
			framePeak_next = runMax_reg;
		end else begin
			runMax_next = (pc_reg > runMax_reg) ? pc_reg : runMax_reg;
			framePeak_next = framePeak_reg;
		end
		if (clearFall) begin
			allPeak_next = pcm_pkg::PC_RESET;
		end else if (newPeak) begin
			allPeak_next = runMax_reg;
		end else begin
			allPeak_next = allPeak_reg;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			pc_reg <= pcm_pkg::PC_RESET;
			runMax_reg <= pcm_pkg::PC_RESET;
			framePeak_reg <= pcm_pkg::PC_RESET;
			allPeak_reg <= pcm_pkg::PC_RESET;
			clear_reg <= 1'b0;
			clrPrev_reg <= 1'b0;
		end else begin
			pc_reg <= pc_next;
			runMax_reg <= runMax_next;
			framePeak_reg <= framePeak_next;
			allPeak_reg <= allPeak_next;
			clear_reg <= clear_next;
			clrPrev_reg <= clrPrev_next;
		end
	end

	// =================================================================
	// counter and peak checks
	property p_pc_stable;
		@(posedge core_clk) disable iff (!nrst)
		!clear_reg && !corePcValid |=> $stable(pc_reg);
	endproperty
	a_pc_stable: assert property (p_pc_stable) else $error("counter moved unloaded");

	property p_hold_write;
		@(posedge core_clk) disable iff (!nrst)
		regWrStb && regAddr == pcm_pkg::OFF_CLEAR
		|=> pcHold == $past(regWrData[pcm_pkg::CLEAR_BIT]);
	endproperty
	a_hold_write: assert property (p_hold_write) else $error("hold mismatch");

	property p_runmax_clr;
		@(posedge core_clk) disable iff (!nrst)
		clear_reg |=> runMax_reg == pcm_pkg::PC_RESET;
	endproperty
	a_runmax_clr: assert property (p_runmax_clr) else $error("running maximum kept");

	property p_runmax_trk;
		@(posedge core_clk) disable iff (!nrst)
		!frameStart && !clear_reg |=> runMax_reg >= $past(pc_reg);
	endproperty
	a_runmax_trk: assert property (p_runmax_trk) else $error("running maximum low");

	property p_frame_keep;
		@(posedge core_clk) disable iff (!nrst)
		!frameStart && !clear_reg |=> $stable(framePeak_reg);
	endproperty
	a_frame_keep: assert property (p_frame_keep) else $error("frame peak moved");

	property p_all_take;
		@(posedge core_clk) disable iff (!nrst)
		newPeak |=> allPeak_reg == $past(runMax_reg);
	endproperty
	a_all_take: assert property (p_all_take) else $error("new peak not taken");

	property p_all_keep;
		@(posedge core_clk) disable iff (!nrst)
		!newPeak && !clearFall |=> $stable(allPeak_reg);
	endproperty
	a_all_keep: assert property (p_all_keep) else $error("all-time peak moved");

	property p_all_cover;
		@(posedge core_clk) disable iff (!nrst)
		frameStart && !clear_reg && !clearFall |=> allPeak_reg >= $past(runMax_reg);
	endproperty
	a_all_cover: assert property (p_all_cover) else $error("all-time below peak");

	property p_frame_event;
		@(posedge core_clk) disable iff (!nrst)
		frameStart && !clear_reg |=> istat_reg[pcm_pkg::IRQ_FRAME_DONE];
	endproperty
	a_frame_event: assert property (p_frame_event) else $error("frame status not set");

	property p_peak_event;
		@(posedge core_clk) disable iff (!nrst)
		newPeak |=> istat_reg[pcm_pkg::IRQ_NEW_PEAK];
	endproperty
	a_peak_event: assert property (p_peak_event) else $error("peak status not set");

	// =================================================================
	// parity mask and interrupt registers
	always_comb begin
		pmask_next = pmask_reg;
		imask_next = imask_reg;
		istat_next = istat_reg;
		if (wrHit && hit(regAddr, pcm_pkg::OFF_PARITY_MASK)) begin
			pmask_next = regWrData & pcm_pkg::PARITY_RW_BITS;
		end else if (wrHit && hit(regAddr, pcm_pkg::OFF_IRQ_MASK)) begin
			imask_next = regWrData[2:0] & pcm_pkg::IRQ_RW_BITS;
		end else if (wrHit && hit(regAddr, pcm_pkg::OFF_IRQ_STATUS)) begin
			istat_next = istat_reg & ~regWrData[2:0];
		end
		// set applied last so a new event beats a simultaneous clear
		istat_next = istat_next | events;
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			pmask_reg <= pcm_pkg::REG_RESET;
			imask_reg <= pcm_pkg::IRQ_RESET;
			istat_reg <= pcm_pkg::IRQ_RESET;
		end else begin
			pmask_reg <= pmask_next;
			imask_reg <= imask_next;
			istat_reg <= istat_next;
		end
	end

	// =================================================================
	// parity mask checks
	property p_mask_wr;
		@(posedge core_clk) disable iff (!nrst)
		regWrStb && regAddr == pcm_pkg::OFF_PARITY_MASK
		|=> pmask_reg == ($past(regWrData) & pcm_pkg::PARITY_RW_BITS);
	endproperty
	a_mask_wr: assert property (p_mask_wr) else $error("mask write lost");

	// a parity status bit only rises after an error that got past its mask
	property p_parity_stat;
		@(posedge core_clk) disable iff (!nrst)
		$rose(istat_reg[pcm_pkg::IRQ_PARITY]) |-> $past(panicParity);
	endproperty
	a_parity_stat: assert property (p_parity_stat) else $error("masked error flagged");

	// each subbank alone: error input i pairs with mask bit SUB_LSB + i
	for (genvar i = 0; i < 4; i++) begin : g_sub
		property p_sub_off;
			@(posedge core_clk) disable iff (!nrst)
			pmask_reg[pcm_pkg::SUB_LSB + i] && subParityErr == (4'h1 << i) |-> !panicParity;
		endproperty
		a_sub_off: assert property (p_sub_off) else $error("masked subbank seen");

		property p_sub_on;
			@(posedge core_clk) disable iff (!nrst)
			subParityErr[i] && !pmask_reg[pcm_pkg::SUB_LSB + i] |-> panicParity;
		endproperty
		a_sub_on: assert property (p_sub_on) else $error("subbank error lost");
	end

	// =================================================================
	// read path, unmapped addresses read zero
	always_comb begin
		rd_next = 16'h0000;
		if (!regRdStb) begin
			rd_next = 16'h0000;
		end else if (hit(regAddr, pcm_pkg::OFF_PC_HIGH)) begin
			rd_next = {8'h00, pc_reg[23:16]};
		end else if (hit(regAddr, pcm_pkg::OFF_PC_LOW)) begin
			rd_next = pc_reg[15:0];
		end else if (hit(regAddr, pcm_pkg::OFF_CLEAR)) begin
			rd_next = {15'h0000, clear_reg};
		end else if (hit(regAddr, pcm_pkg::OFF_FRAME_HIGH)) begin
			rd_next = {8'h00, framePeak_reg[23:16]};
		end else if (hit(regAddr, pcm_pkg::OFF_FRAME_LOW)) begin
			rd_next = framePeak_reg[15:0];
		end else if (hit(regAddr, pcm_pkg::OFF_ALL_HIGH)) begin
			rd_next = {8'h00, allPeak_reg[23:16]};
		end else if (hit(regAddr, pcm_pkg::OFF_ALL_LOW)) begin
			rd_next = allPeak_reg[15:0];
		end else if (hit(regAddr, pcm_pkg::OFF_PARITY_MASK)) begin
			rd_next = pmask_reg;
		end else if (hit(regAddr, pcm_pkg::OFF_IRQ_STATUS)) begin
			rd_next = {13'h0000, istat_reg};
		end else if (hit(regAddr, pcm_pkg::OFF_IRQ_MASK)) begin
			rd_next = {13'h0000, imask_reg};
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rd_reg <= pcm_pkg::REG_RESET;
		end else begin
			rd_reg <= rd_next;
		end
	end

	assign regRdData = rd_reg;
	assign pcHold = clear_reg;
	// only unmasked subbanks reach the panic flag
	assign panicParity = |reported;
	assign irq = |(istat_reg & imask_reg);

	// =================================================================
	// read path checks
	property p_rd_idle;
		@(posedge core_clk) disable iff (!nrst)
		!regRdStb |=> regRdData == 16'h0000;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");

	property p_read_high;
		@(posedge core_clk) disable iff (!nrst)
		regRdStb && regAddr == pcm_pkg::OFF_PC_HIGH
		|=> regRdData == {8'h00, $past(pc_reg[23:16])};
	endproperty
	a_read_high: assert property (p_read_high) else $error("wrong counter high");

	property p_read_clr;
		@(posedge core_clk) disable iff (!nrst)
		regRdStb && regAddr == pcm_pkg::OFF_CLEAR
		|=> regRdData == {15'h0000, $past(clear_reg)};
	endproperty
	a_read_clr: assert property (p_read_clr) else $error("wrong clear read");

	property p_read_fhi;
		@(posedge core_clk) disable iff (!nrst)
		regRdStb && regAddr == pcm_pkg::OFF_FRAME_HIGH
		|=> regRdData == {8'h00, $past(framePeak_reg[23:16])};
	endproperty
	a_read_fhi: assert property (p_read_fhi) else $error("wrong frame high");

	property p_read_flo;
		@(posedge core_clk) disable iff (!nrst)
		regRdStb && regAddr == pcm_pkg::OFF_FRAME_LOW
		|=> regRdData == $past(framePeak_reg[15:0]);
	endproperty
	a_read_flo: assert property (p_read_flo) else $error("wrong frame low");

	property p_read_ahi;
		@(posedge core_clk) disable iff (!nrst)
		regRdStb && regAddr == pcm_pkg::OFF_ALL_HIGH
		|=> regRdData == {8'h00, $past(allPeak_reg[23:16])};
	endproperty
	a_read_ahi: assert property (p_read_ahi) else $error("wrong all-time high");

	property p_read_alo;
		@(posedge core_clk) disable iff (!nrst)
		regRdStb && regAddr == pcm_pkg::OFF_ALL_LOW
		|=> regRdData == $past(allPeak_reg[15:0]);
	endproperty
	a_read_alo: assert property (p_read_alo) else $error("wrong all-time low");

	property p_read_mask;
		@(posedge core_clk) disable iff (!nrst)
		regRdStb && regAddr == pcm_pkg::OFF_PARITY_MASK
		|=> regRdData == $past(pmask_reg);
	endproperty
	a_read_mask: assert property (p_read_mask) else $error("wrong mask read");

	// =================================================================
	// checks
	property p_clear_zero;
		@(posedge core_clk) disable iff (!nrst)
		clear_reg |=> (pc_reg == 24'h000000) && (framePeak_reg == 24'h000000);
	endproperty
	a_clear_zero: assert property (p_clear_zero) else $error("counter not zero under clear");

	property p_follow;
		@(posedge core_clk) disable iff (!nrst)
		!clear_reg && corePcValid |=> pc_reg == $past(corePc);
	endproperty
	a_follow: assert property (p_follow) else $error("counter not following core");

	property p_alltime_clear;
		@(posedge core_clk) disable iff (!nrst)
		$fell(clear_reg) |=> allPeak_reg == 24'h000000;
	endproperty
	a_alltime_clear: assert property (p_alltime_clear) else $error("all-time peak kept");

	property p_frame_latch;
		@(posedge core_clk) disable iff (!nrst)
		frameStart && !clear_reg |=> framePeak_reg == $past(runMax_reg);
	endproperty
	a_frame_latch: assert property (p_frame_latch) else $error("frame peak not latched");

	property p_alltime_grow;
		@(posedge core_clk) disable iff (!nrst)
		!clearFall |=> allPeak_reg >= $past(allPeak_reg);
	endproperty
	a_alltime_grow: assert property (p_alltime_grow) else $error("all-time peak fell");

	property p_masked;
		@(posedge core_clk) disable iff (!nrst)
		(&pmask_reg[12:9]) |-> !panicParity;
	endproperty
	a_masked: assert property (p_masked) else $error("masked error reported");

	property p_report;
		@(posedge core_clk) disable iff (!nrst)
		(subParityErr[0] && !pmask_reg[9]) |-> panicParity;
	endproperty
	a_report: assert property (p_report) else $error("unmasked error lost");

	property p_read_low;
		@(posedge core_clk) disable iff (!nrst)
		regRdStb && regAddr == 16'hf461 |=> regRdData == $past(pc_reg[15:0]);
	endproperty
	a_read_low: assert property (p_read_low) else $error("wrong counter read");

	property p_mask_rw;
		@(posedge core_clk) disable iff (!nrst)
		regWrStb && regAddr == 16'hf467 ##1 regRdStb && regAddr == 16'hf467
		|=> regRdData == ($past(regWrData, 2) & 16'h1f1f);
	endproperty
	a_mask_rw: assert property (p_mask_rw) else $error("mask readback wrong");

	property p_irq;
		@(posedge core_clk) disable iff (!nrst)
		events[2] && imask_reg[2] |=> irq [*2];
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt missing");
endmodule : pcm_pc_monitor

// File: test_pcm_pc_monitor.sv
// self-checking bench of the program counter monitor and first parity mask
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin errTotal++; \
	$display("ERROR %s expected %h seen %h", nm, ex, got); end end
module test_pcm_pc_monitor;
	// =================================================================
	// stimulus and observation
	logic core_clk, nrst, regWrStb, regRdStb, corePcValid, frameStart;
	logic [15:0] regAddr, regWrData, regRdData;
	logic [23:0] corePc;
	logic [3:0] subParityErr;
	logic pcHold, panicParity, irq;
	int errTotal, comparisons;
	// every mapped place plus one unmapped, all zero out of reset
	logic [15:0] rstAddr [11] = '{16'hf460, 16'hf461, 16'hf462, 16'hf463, 16'hf464,
		16'hf465, 16'hf466, 16'hf467, 16'hf470, 16'hf471, 16'hf46f};
	pcm_pc_monitor u_dut (.core_clk(core_clk), .nrst(nrst), .regAddr(regAddr),
		.regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
		.regRdData(regRdData), .corePc(corePc), .corePcValid(corePcValid),
		.frameStart(frameStart), .pcHold(pcHold), .subParityErr(subParityErr),
		.panicParity(panicParity), .irq(irq));
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	// =================================================================
	// bus and core tasks
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge core_clk);
		regAddr <= a;
		regWrData <= d;
		regWrStb <= 1'b1;
		@(posedge core_clk);
		regWrStb <= 1'b0;
	endtask : wr
	// read data stand only in the cycle after the strobe, so sample mid-cycle there
	task automatic rd(input logic [15:0] a, input logic [15:0] ex);
		@(posedge core_clk);
		regAddr <= a;
		regRdStb <= 1'b1;
		@(posedge core_clk);
		regRdStb <= 1'b0;
		@(negedge core_clk);
		`CHK("regRdData", ex, regRdData)
	endtask : rd
	// write then read the same place with the two strobes back to back
	task automatic wrRd(input logic [15:0] a, input logic [15:0] d, input logic [15:0] ex);
		@(posedge core_clk);
		regAddr <= a;
		regWrData <= d;
		regWrStb <= 1'b1;
		@(posedge core_clk);
		regWrStb <= 1'b0;
		regRdStb <= 1'b1;
		@(posedge core_clk);
		regRdStb <= 1'b0;
		@(negedge core_clk);
		`CHK("regRdData", ex, regRdData)
	endtask : wrRd
	task automatic loadPc(input logic [23:0] v);
		@(posedge core_clk);
		corePc <= v;
		corePcValid <= 1'b1;
		@(posedge core_clk);
		corePcValid <= 1'b0;
	endtask : loadPc
	// idle cycles first so the running maximum has seen the new counter value
	task automatic pulseFrame();
		repeat (3) @(posedge core_clk);
		frameStart <= 1'b1;
		@(posedge core_clk);
		frameStart <= 1'b0;
		@(posedge core_clk);
	endtask : pulseFrame
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, errTotal);
		if (errTotal == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : print_verdict
	// =================================================================
	// watchdog, far beyond the roughly 150 cycles the tests need
	initial begin
		#200000;
		errTotal++;
		print_verdict();
	end
	// =================================================================
	// tests
	initial begin
		{nrst, regWrStb, regRdStb, corePcValid, frameStart} = 5'h00;
		{regAddr, regWrData, corePc, subParityErr} = '0;
		errTotal = 0;
		comparisons = 0;
		repeat (12) @(posedge core_clk);
		nrst <= 1'b1;
		wr(16'hf4ff, 16'hffff);
		foreach (rstAddr[i]) rd(rstAddr[i], 16'h0000);
		@(negedge core_clk);
		`CHK("pcHold", 1'b0, pcHold)
		// live counter and its halves, low half not writable
		loadPc(24'h12abcd);
		rd(16'hf460, 16'h0012);
		wr(16'hf461, 16'hffff);
		rd(16'hf461, 16'habcd);
		// first frame: new all-time peak
		wr(16'hf471, 16'h0003);
		pulseFrame();
		rd(16'hf463, 16'h0012);
		rd(16'hf464, 16'habcd);
		rd(16'hf465, 16'h0012);
		rd(16'hf466, 16'habcd);
		rd(16'hf470, 16'h0003);
		`CHK("irq", 1'b1, irq)
		wr(16'hf470, 16'h0003);
		rd(16'hf470, 16'h0000);
		`CHK("irq", 1'b0, irq)
		// lower peaks must leave the all-time record alone
		loadPc(24'h000100);
		pulseFrame();
		rd(16'hf470, 16'h0002);
		pulseFrame();
		rd(16'hf463, 16'h0000);
		rd(16'hf464, 16'h0100);
		rd(16'hf465, 16'h0012);
		rd(16'hf466, 16'habcd);
		// clear sequence
		wr(16'hf462, 16'h0001);
		@(negedge core_clk);
		`CHK("pcHold", 1'b1, pcHold)
		loadPc(24'h003000);
		rd(16'hf462, 16'h0001);
		rd(16'hf460, 16'h0000);
		rd(16'hf461, 16'h0000);
		rd(16'hf463, 16'h0000);
		rd(16'hf464, 16'h0000);
		wr(16'hf462, 16'h0000);
		@(negedge core_clk);
		`CHK("pcHold", 1'b0, pcHold)
		rd(16'hf465, 16'h0000);
		rd(16'hf466, 16'h0000);
		loadPc(24'h000042);
		rd(16'hf461, 16'h0042);
		// parity masks, one subbank at a time
		for (int i = 0; i < 4; i++) begin
			@(posedge core_clk);
			subParityErr <= 4'h1 << i;
			@(negedge core_clk);
			`CHK("panicParity", 1'b1, panicParity)
			wr(16'hf467, 16'h0200 << i);
			@(negedge core_clk);
			`CHK("panicParity", 1'b0, panicParity)
			@(posedge core_clk);
			subParityErr <= 4'hf;
			@(negedge core_clk);
			`CHK("panicParity", 1'b1, panicParity)
			wr(16'hf467, 16'h0000);
		end
		wrRd(16'hf467, 16'hffff, 16'h1f1f);
		`CHK("panicParity", 1'b0, panicParity)
		// parity status raises the interrupt only once enabled and unmasked
		wr(16'hf470, 16'h0007);
		wr(16'hf471, 16'h0004);
		rd(16'hf470, 16'h0000);
		`CHK("irq", 1'b0, irq)
		wr(16'hf467, 16'h0000);
		repeat (2) @(negedge core_clk);
		`CHK("irq", 1'b1, irq)
		@(posedge core_clk);
		subParityErr <= 4'h0;
		wr(16'hf470, 16'h0004);
		rd(16'hf470, 16'h0000);
		`CHK("irq", 1'b0, irq)
		print_verdict();
	end
endmodule : test_pcm_pc_monitor
